// ---- pkg/exec_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants for the return and jump execution block
// ----------------------------------------------------------------------------
package exec_pkg;

   // ------------------------------------------------------------------------
   // Opcodes and decode fields
   // ------------------------------------------------------------------------
   localparam logic [7:0] OPC_INTERRUPT_RETURN       = 8'hBF;  // Both interrupt_return forms
   localparam logic [7:0] OPC_JP_IRR     = 8'h30;  // Unconditional indirect jump
   localparam logic [3:0] OPC_JP_DA_NIB  = 4'hD;   // Low nibble of conditional jump

   // ------------------------------------------------------------------------
   // Cycle counts per instruction form
   // ------------------------------------------------------------------------
   localparam logic [3:0] CYC_INTERRUPT_RETURN_NORMAL = 4'hA;  // Stack return, internal stack
   localparam logic [3:0] CYC_INTERRUPT_RETURN_FAST   = 4'h6;  // Pointer swap return
   localparam logic [3:0] CYC_JP_TAKEN    = 4'h8;  // Conditional jump, taken
   localparam logic [3:0] CYC_JP_SKIP     = 4'h6;  // Conditional jump, not taken
   localparam logic [3:0] CYC_JP_IRR      = 4'h8;  // Indirect jump
   localparam logic [3:0] CYC_ILLEGAL     = 4'h2;  // Unknown opcode, no effect

   // ------------------------------------------------------------------------
   // Instruction lengths and flag bits
   // ------------------------------------------------------------------------
   localparam logic [15:0] LEN_JP_DA     = 16'h0003; // Three-byte direct format
   localparam int          FIS_BIT       = 1;        // fast_interrupt_status
   localparam int          GIE_BIT       = 0;        // Global enable in mode reg

   // ------------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------------
   localparam logic [8:0] IDX_FLAGS = 9'h0D5;  // processor_flags
   localparam logic [8:0] IDX_PC    = 9'h100;  // Program counter
   localparam logic [8:0] IDX_SP    = 9'h101;  // Stack pointer
   localparam logic [8:0] IDX_IP    = 9'h102;  // fast_return_pointer
   localparam logic [8:0] IDX_SYM   = 9'h103;  // system_mode_register
   localparam logic [8:0] IDX_INSTR = 9'h104;  // Instruction bytes 0..2
   localparam logic [8:0] IDX_COND  = 9'h105;  // Condition truth mask
   localparam logic [8:0] IDX_CTRL  = 9'h106;  // Command write, status read

   // ------------------------------------------------------------------------
   // Command and status bits
   // ------------------------------------------------------------------------
   localparam int CTRL_GO_BIT   = 0;  // Execute held instruction
   localparam int CTRL_FAST_BIT = 1;  // Take a fast interrupt
   localparam int ST_BUSY_BIT   = 0;  // Execution in progress
   localparam int ST_TAKEN_BIT  = 1;  // Last jump changed the PC
   localparam int ST_ILL_BIT    = 2;  // Last opcode not recognised
   localparam int ST_CYC_LSB    = 8;  // Cycle count of last instruction

   // ------------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------------
   localparam logic [15:0] RST_PC    = 16'h0000;
   localparam logic [7:0]  RST_SP    = 8'h00;
   localparam logic [15:0] RST_IP    = 16'h0000;
   localparam logic [7:0]  RST_SYM   = 8'h00;
   localparam logic [7:0]  RST_FLAGS = 8'h00;
   localparam logic [15:0] RST_COND  = 16'h0000;

   // ------------------------------------------------------------------------
   // Execution states
   // ------------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_FETCH, ST_POP_FLAGS, ST_POP_PCH, ST_POP_PCL,
      ST_FAST, ST_JP_DA, ST_PAIR_HI, ST_PAIR_LO, ST_HOLD
   } exec_state_type;

endpackage : exec_pkg

// ---- pkg/regfile_if.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Register file port between the executor and its storage
// ----------------------------------------------------------------------------
interface regfile_if;
   logic [7:0] rd_addr;  // Asynchronous read address
   logic [7:0] rd_data;  // Read data
   logic       wr_en;    // Write strobe
   logic [7:0] wr_addr;  // Write address
   logic [7:0] wr_data;  // Write data

   modport owner (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
   modport store (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : regfile_if

// ---- rtl/regfile_store.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Register file holding the internal stack and working registers
// ----------------------------------------------------------------------------
module regfile_store
   import exec_pkg::*;
(
   input wire logic clk,
   regfile_if.store rf
);

   logic [7:0] mem [0:255];  // Byte storage, no reset

   // Synchronous write
   always_ff @(posedge clk) begin
      if (rf.wr_en) begin
         mem[rf.wr_addr] <= rf.wr_data;
      end
   end

   // Combinational read
   assign rf.rd_data = mem[rf.rd_addr];

endmodule : regfile_store

// ---- rtl/exec_core.sv ----
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// How it works
// - Normal return pops flags, then PC; SP advances.
// - Any return sets mode register bit zero.
// - Stack return only when fast status clear.
// - Fast return swaps PC/pointer, restores flags, clears status.
// - Opcode BF; normal 10 cycles, fast 6.
// - Fast interrupt entry swaps PC and pointer.
// - False condition: PC simply advances past jump.
// - Condition in high nibble, D in low.
// - Direct jump three bytes, 8 or 6 cycles.
// - Opcode 30 jumps through register pair, 8 cycles.
module exec_core
   import exec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [8:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             busy,
   output logic             global_int_enable,
   output logic             fast_interrupt_status,
   output logic [15:0]      program_counter
);

   // ------------------------------------------------------------------------
   // State record
   // ------------------------------------------------------------------------
   typedef struct packed {
      exec_state_type state;    // Sequencer state
      logic [15:0]    pc;       // Program counter
      logic [7:0]     sp;       // Stack pointer
      logic [15:0]    ip;       // fast_return_pointer
      logic [7:0]     system_mode_register;      // system_mode_register
      logic [7:0]     flags;    // processor_flags
      logic [7:0]     shadow;   // Saved flags for fast return
      logic [23:0]    instr;    // Instruction bytes
      logic [15:0]    cond;     // Condition truth mask
      logic [7:0]     tmp;      // High byte being assembled
      logic [3:0]     cnt;      // Cycles since execution start
      logic [3:0]     target;   // Cycles this instruction takes
      logic           busy;     // Execution running
      logic           taken;    // Last jump taken
      logic           illegal;  // Last opcode unknown
      logic           wait_q;   // Bus waitrequest
      logic [31:0]    rdata;    // Bus read data
   } core_state_type;

   core_state_type s_q;  // Registered state
   core_state_type s_d;  // Next state

   regfile_if rf ();  // Storage port

   logic        req;     // Bus request present
   logic        accept;  // Request completes this edge
   logic [31:0] rval;    // Read value for addressed register
   logic [31:0] wm;      // Byte-merged write value
   logic [7:0]  opcode;  // Instruction byte 0
   logic [7:0]  op1;     // Instruction byte 1
   logic [7:0]  op2;     // Instruction byte 2

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------

   // Merge write data into old value under byte enables
   function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   // Truth of a condition code
   function automatic logic cond_hit(input logic [15:0] mask, input logic [3:0] cc);
      return mask[cc];
   endfunction : cond_hit

   // ------------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------------
   regfile_store u_store (
      .clk (clk),
      .rf  (rf.store)
   );

   assign opcode = s_q.instr[7:0];
   assign op1    = s_q.instr[15:8];
   assign op2    = s_q.instr[23:16];
   assign req    = avs_read | avs_write;
   assign accept = req & ~s_q.wait_q;

   // Read mux for the bus
   always_comb begin
      rval = 32'h0000_0000;
      if (avs_address == IDX_FLAGS) begin
         rval = {24'h000000, s_q.flags};
      end else if (!avs_address[8]) begin
         rval = {24'h000000, rf.rd_data};
      end else begin
         case (avs_address)
            IDX_PC:    rval = {16'h0000, s_q.pc};
            IDX_SP:    rval = {24'h000000, s_q.sp};
            IDX_IP:    rval = {16'h0000, s_q.ip};
            IDX_SYM:   rval = {24'h000000, s_q.system_mode_register};
            IDX_INSTR: rval = {8'h00, s_q.instr};
            IDX_COND:  rval = {16'h0000, s_q.cond};
            IDX_CTRL:  rval = {20'h00000, s_q.target, 5'h00, s_q.illegal, s_q.taken, s_q.busy};
            default:   rval = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------------
   always_comb begin
      s_d        = s_q;
      wm         = 32'h0000_0000;
      rf.rd_addr = avs_address[7:0];
      rf.wr_en   = 1'b0;
      rf.wr_addr = avs_address[7:0];
      rf.wr_data = avs_writedata[7:0];

      // Bus: one wait cycle, then answer; stalled while executing
      s_d.wait_q = 1'b1;
      if (req && s_q.wait_q && !s_q.busy) begin
         s_d.wait_q = 1'b0;
         s_d.rdata  = rval;
      end

      // Register writes at the completing edge
      if (accept && avs_write) begin
         if (avs_address == IDX_FLAGS) begin
            wm        = merge_be({24'h000000, s_q.flags}, avs_writedata, avs_byteenable);
            s_d.flags = wm[7:0];
         end else if (!avs_address[8]) begin
            rf.wr_en = avs_byteenable[0];
         end else begin
            case (avs_address)
               IDX_PC: begin
                  wm     = merge_be({16'h0000, s_q.pc}, avs_writedata, avs_byteenable);
                  s_d.pc = wm[15:0];
               end
               IDX_SP: begin
                  wm     = merge_be({24'h000000, s_q.sp}, avs_writedata, avs_byteenable);
                  s_d.sp = wm[7:0];
               end
               IDX_IP: begin
                  wm     = merge_be({16'h0000, s_q.ip}, avs_writedata, avs_byteenable);
                  s_d.ip = wm[15:0];
               end
               IDX_SYM: begin
                  wm      = merge_be({24'h000000, s_q.system_mode_register}, avs_writedata, avs_byteenable);
                  s_d.system_mode_register = wm[7:0];
               end
               IDX_INSTR: begin
                  wm        = merge_be({8'h00, s_q.instr}, avs_writedata, avs_byteenable);
                  s_d.instr = wm[23:0];
               end
               IDX_COND: begin
                  wm       = merge_be({16'h0000, s_q.cond}, avs_writedata, avs_byteenable);
                  s_d.cond = wm[15:0];
               end
               IDX_CTRL: begin
                  if (avs_byteenable[0] && avs_writedata[CTRL_GO_BIT]) begin
                     // Start execution of the held instruction
                     s_d.state   = ST_FETCH;
                     s_d.busy    = 1'b1;
                     s_d.cnt     = 4'h0;
                     s_d.taken   = 1'b0;
                     s_d.illegal = 1'b0;
                  end else if (avs_byteenable[0] && avs_writedata[CTRL_FAST_BIT]) begin
                     // Fast interrupt entry: swap, save flags, mark status
                     s_d.pc              = s_q.ip;
                     s_d.ip              = s_q.pc;
                     s_d.shadow          = s_q.flags;
                     s_d.flags[FIS_BIT]  = 1'b1;
                  end
               end
               default: ;  // Unmapped: write ignored
            endcase
         end
      end

      // Execution sequencer
      if (s_q.busy) begin
         s_d.cnt = s_q.cnt + 4'h1;
      end
      case (s_q.state)
         ST_IDLE: ;
         ST_FETCH: begin
            if (opcode == OPC_INTERRUPT_RETURN) begin
               if (!s_q.flags[FIS_BIT]) begin
                  s_d.state  = ST_POP_FLAGS;
                  s_d.target = CYC_INTERRUPT_RETURN_NORMAL;
               end else begin
                  s_d.state  = ST_FAST;
                  s_d.target = CYC_INTERRUPT_RETURN_FAST;
               end
            end else if (opcode[3:0] == OPC_JP_DA_NIB) begin
               s_d.state  = ST_JP_DA;
               s_d.target = cond_hit(s_q.cond, opcode[7:4]) ? CYC_JP_TAKEN : CYC_JP_SKIP;
            end else if (opcode == OPC_JP_IRR) begin
               s_d.state  = ST_PAIR_HI;
               s_d.target = CYC_JP_IRR;
            end else begin
               s_d.state   = ST_HOLD;
               s_d.target  = CYC_ILLEGAL;
               s_d.illegal = 1'b1;
            end
         end
         ST_POP_FLAGS: begin
            rf.rd_addr = s_q.sp;
            s_d.flags  = rf.rd_data;
            s_d.sp     = s_q.sp + 8'h01;
            s_d.state  = ST_POP_PCH;
         end
         ST_POP_PCH: begin
            rf.rd_addr = s_q.sp;
            s_d.tmp    = rf.rd_data;
            s_d.state  = ST_POP_PCL;
         end
         ST_POP_PCL: begin
            rf.rd_addr        = s_q.sp + 8'h01;
            s_d.pc            = {s_q.tmp, rf.rd_data};
            s_d.sp            = s_q.sp + 8'h02;
            s_d.system_mode_register[GIE_BIT]  = 1'b1;
            s_d.state         = ST_HOLD;
         end
         ST_FAST: begin
            s_d.pc               = s_q.ip;
            s_d.ip               = s_q.pc;
            s_d.flags            = s_q.shadow;
            s_d.flags[FIS_BIT]   = 1'b0;
            s_d.system_mode_register[GIE_BIT]     = 1'b1;
            s_d.state            = ST_HOLD;
         end
         ST_JP_DA: begin
            if (cond_hit(s_q.cond, opcode[7:4])) begin
               s_d.pc    = {op1, op2};
               s_d.taken = 1'b1;
            end else begin
               s_d.pc = s_q.pc + LEN_JP_DA;
            end
            s_d.state = ST_HOLD;
         end
         ST_PAIR_HI: begin
            rf.rd_addr = {op1[7:1], 1'b0};
            s_d.tmp    = rf.rd_data;
            s_d.state  = ST_PAIR_LO;
         end
         ST_PAIR_LO: begin
            rf.rd_addr = {op1[7:1], 1'b1};
            s_d.pc     = {s_q.tmp, rf.rd_data};
            s_d.taken  = 1'b1;
            s_d.state  = ST_HOLD;
         end
         ST_HOLD: begin
            // Pad out to the instruction's cycle count
            if (s_q.cnt == s_q.target - 4'h1) begin
               s_d.busy  = 1'b0;
               s_d.state = ST_IDLE;
            end
         end
         default: s_d.state = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{state: ST_IDLE, pc: RST_PC, sp: RST_SP, ip: RST_IP, system_mode_register: RST_SYM,
                  flags: RST_FLAGS, shadow: RST_FLAGS, instr: 24'h000000, cond: RST_COND,
                  tmp: 8'h00, cnt: 4'h0, target: 4'h0, busy: 1'b0, taken: 1'b0,
                  illegal: 1'b0, wait_q: 1'b1, rdata: 32'h0000_0000};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata          = s_q.rdata;
   assign avs_waitrequest       = s_q.wait_q;
   assign busy                  = s_q.busy;
   assign global_int_enable     = s_q.system_mode_register[GIE_BIT];
   assign fast_interrupt_status = s_q.flags[FIS_BIT];
   assign program_counter       = s_q.pc;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_start_norm;
      s_q.state == ST_FETCH && opcode == OPC_INTERRUPT_RETURN && !s_q.flags[FIS_BIT];
   endsequence

   sequence s_start_fast;
      s_q.state == ST_FETCH && opcode == OPC_INTERRUPT_RETURN && s_q.flags[FIS_BIT];
   endsequence

   sequence s_start_jp_skip;
      s_q.state == ST_FETCH && opcode[3:0] == OPC_JP_DA_NIB && !cond_hit(s_q.cond, opcode[7:4]);
   endsequence

   property p_interrupt_return_sp;
      s_start_norm |-> ##10 (s_q.sp == $past(s_q.sp, 10) + 8'h03) && !s_q.busy;
   endproperty
   a_interrupt_return_sp: assert property (p_interrupt_return_sp) else $error("stack pointer not advanced by three");

   property p_interrupt_return_gie;
      s_start_fast |-> ##6 s_q.system_mode_register[GIE_BIT];
   endproperty
   a_interrupt_return_gie: assert property (p_interrupt_return_gie) else $error("global enable not set by return");

   property p_interrupt_return_select;
      s_start_norm |=> s_q.state == ST_POP_FLAGS;
   endproperty
   a_interrupt_return_select: assert property (p_interrupt_return_select) else $error("stack return not chosen");

   property p_fast_swap;
      s_q.state == ST_FAST |=> s_q.pc == $past(s_q.ip) && s_q.ip == $past(s_q.pc)
                               && !s_q.flags[FIS_BIT];
   endproperty
   a_fast_swap: assert property (p_fast_swap) else $error("fast return swap wrong");

   property p_fast_len;
      s_start_fast |-> ##5 s_q.busy ##1 !s_q.busy;
   endproperty
   a_fast_len: assert property (p_fast_len) else $error("fast return not six cycles");

   property p_entry_swap;
      accept && avs_write && avs_address == IDX_CTRL && !avs_writedata[CTRL_GO_BIT]
         && avs_writedata[CTRL_FAST_BIT] && avs_byteenable[0]
         |=> s_q.pc == $past(s_q.ip) && s_q.flags[FIS_BIT];
   endproperty
   a_entry_swap: assert property (p_entry_swap) else $error("fast entry swap wrong");

   property p_jp_skip;
      s_start_jp_skip |-> ##2 s_q.pc == $past(s_q.pc, 2) + LEN_JP_DA ##4 !s_q.busy;
   endproperty
   a_jp_skip: assert property (p_jp_skip) else $error("false jump did not fall through");

   property p_jp_decode;
      s_q.state == ST_FETCH && opcode[3:0] == OPC_JP_DA_NIB |=> s_q.state == ST_JP_DA;
   endproperty
   a_jp_decode: assert property (p_jp_decode) else $error("conditional jump not decoded");

   property p_jp_taken;
      s_q.state == ST_JP_DA && cond_hit(s_q.cond, opcode[7:4])
         |=> s_q.pc == {op1, op2} ##6 !s_q.busy;
   endproperty
   a_jp_taken: assert property (p_jp_taken) else $error("taken jump target or length wrong");

   property p_irr_len;
      s_q.state == ST_FETCH && opcode == OPC_JP_IRR |-> ##7 s_q.busy ##1 !s_q.busy;
   endproperty
   a_irr_len: assert property (p_irr_len) else $error("indirect jump not eight cycles");

   property p_pair_order;
      s_q.state == ST_PAIR_HI |-> !rf.rd_addr[0] ##1 rf.rd_addr[0] ##1 s_q.pc[15:8] == s_q.tmp;
   endproperty
   a_pair_order: assert property (p_pair_order) else $error("register pair byte order wrong");

endmodule : exec_core

// ---- verif/exec_core_tb.sv ----
`timescale 1ns/1ps
module exec_core_tb;
   import exec_pkg::*;
   // ------------------------------------------------------------------------
   // Stimulus and observation signals
   // ------------------------------------------------------------------------
   logic        clk;                    // Core clock
   logic        arst_n;                 // Async reset
   logic [8:0]  avs_address;            // Word index
   logic        avs_read;               // Read request
   logic        avs_write;              // Write request
   logic [31:0] avs_writedata;          // Write data
   logic [3:0]  avs_byteenable;         // Byte lanes
   logic [31:0] avs_readdata;           // Read data
   logic        avs_waitrequest;        // Stall
   logic        busy;                   // Execution in progress
   logic        global_int_enable;      // Mode bit zero
   logic        fast_interrupt_status;  // Flags bit one
   logic [15:0] program_counter;        // Current PC
   int          n_mismatch = 0;         // Failed comparisons
   int          check_count = 0;        // All comparisons

   exec_core exec_core_inst (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy),
      .global_int_enable(global_int_enable), .fast_interrupt_status(fast_interrupt_status),
      .program_counter(program_counter));

   // ------------------------------------------------------------------------
   // Clock, 50 ns period
   // ------------------------------------------------------------------------
   always #25 clk = ~clk;

   // ------------------------------------------------------------------------
   // Bus and comparison helpers
   // ------------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk

   // One request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Wait for waitrequest low at a rising edge; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      // Data taken and request dropped at the completing edge
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rdchk(input string nm, input logic [8:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(nm, e, q);
   endtask : rdchk

   // Load an instruction, start it, then judge busy and the cycle count
   task automatic run(input logic [31:0] instr, input logic [3:0] cyc, input logic tk);
      int n;
      wr(IDX_INSTR, instr);
      wr(IDX_CTRL, 32'h0000_0001);
      n = 0;
      @(negedge clk);
      chk("busy", 32'h1, 32'(busy));
      // Count edges until busy falls
      while (busy === 1'b1) begin
         @(negedge clk);
         n++;
      end
      chk("cycles", 32'(cyc), 32'(n));
      rdchk("status", IDX_CTRL, {20'h0, cyc, 6'h0, tk, 1'b0});
   endtask : run

   // ------------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------------
   task automatic t_normal_return;
      wr(IDX_FLAGS, 32'h0000_0000);
      wr(IDX_SP, 32'h0000_0040);
      wr(9'h040, 32'h0000_0081);
      wr(9'h041, 32'h0000_0012);
      wr(9'h042, 32'h0000_0034);
      wr(IDX_SYM, 32'h0000_0000);
      run(32'h0000_00BF, 4'hA, 1'b0);
      chk("pc", 32'h1234, 32'(program_counter));
      rdchk("sp", IDX_SP, 32'h0000_0043);
      rdchk("flags", IDX_FLAGS, 32'h0000_0081);
      chk("gie", 32'h1, 32'(global_int_enable));
      $display("normal return done");
   endtask : t_normal_return

   task automatic t_fast_return;
      wr(IDX_PC, 32'h0000_0050);
      wr(IDX_IP, 32'h0000_0100);
      wr(IDX_FLAGS, 32'h0000_0004);
      wr(IDX_SYM, 32'h0000_0000);
      wr(IDX_CTRL, 32'h0000_0002);
      @(negedge clk);
      chk("pc entry", 32'h0100, 32'(program_counter));
      chk("fis", 32'h1, 32'(fast_interrupt_status));
      rdchk("ip entry", IDX_IP, 32'h0000_0050);
      wr(IDX_FLAGS, 32'h0000_00FA);
      run(32'h0000_00BF, 4'h6, 1'b0);
      chk("pc back", 32'h0050, 32'(program_counter));
      rdchk("ip back", IDX_IP, 32'h0000_0100);
      rdchk("flags", IDX_FLAGS, 32'h0000_0004);
      rdchk("sp kept", IDX_SP, 32'h0000_0043);
      rdchk("mode", IDX_SYM, 32'h0000_0001);
      $display("fast return done");
   endtask : t_fast_return

   // Every condition field, odd ones true
   task automatic t_cond_jump;
      logic [3:0] cc;
      wr(IDX_COND, 32'h0000_AAAA);
      for (int i = 0; i < 16; i++) begin
         cc = 4'(i);
         wr(IDX_PC, 32'h0000_2000);
         run({16'h0010, cc, 4'hD}, cc[0] ? 4'h8 : 4'h6, cc[0]);
         chk("pc jump", cc[0] ? 32'h1000 : 32'h2003, 32'(program_counter));
      end
      $display("conditional jump done");
   endtask : t_cond_jump

   task automatic t_pair_jump;
      wr(9'h020, 32'h0000_0001);
      wr(9'h021, 32'h0000_0020);
      run(32'h0000_2130, 4'h8, 1'b1);
      chk("pc pair", 32'h0120, 32'(program_counter));
      $display("indirect jump done");
   endtask : t_pair_jump

   task automatic t_illegal;
      wr(IDX_PC, 32'h0000_0777);
      wr(IDX_INSTR, 32'h0000_00FF);
      wr(IDX_CTRL, 32'h0000_0001);
      rdchk("ill status", IDX_CTRL, 32'h0000_0204);
      chk("pc kept", 32'h0777, 32'(program_counter));
      rdchk("unmapped", 9'h1FF, 32'h0000_0000);
      $display("illegal and unmapped done");
   endtask : t_illegal

   // ------------------------------------------------------------------------
   // Verdict
   // ------------------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      avs_address = 9'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      chk("rst wait", 32'h1, 32'(avs_waitrequest));
      chk("rst pc", 32'h0, 32'(program_counter));
      chk("rst gie", 32'h0, 32'({busy, global_int_enable, fast_interrupt_status}));
      rdchk("rst flags", IDX_FLAGS, 32'h0000_0000);
      t_normal_return();
      t_fast_return();
      t_cond_jump();
      t_pair_jump();
      t_illegal();
      tally_and_finish();
   end

   initial begin
      #(20000 * 50);
      n_mismatch++;
      tally_and_finish();
   end
endmodule : exec_core_tb
